// [src/abx_pkg.sv]
`default_nettype none
package abx_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FADDR  = 8'h0C;
  localparam logic [7:0] OFS_FDATA  = 8'h10;

  // Status field positions
  localparam int unsigned ST_CARRY  = 0;
  localparam int unsigned ST_NIBBLE = 1;
  localparam int unsigned ST_ZERO   = 2;
  localparam int unsigned ST_SKIP   = 3;

  // File register address that maps onto the I/O port
  localparam logic [6:0] PORT_ADDR = 7'h05;

  // Reset values
  localparam logic [7:0]   RST_ACC   = 8'h00;
  localparam logic [7:0]   RST_LATCH = 8'h00;
  localparam logic [6:0]   RST_FADDR = 7'h00;
  localparam logic [127:0][7:0] RST_MEM = '0;

  // Opcode fields of the 14-bit instruction word
  localparam logic [4:0] OP_ADD_IMM = 5'h1F;
  localparam logic [5:0] OP_AND_IMM = 6'h39;
  localparam logic [5:0] OP_ADD_REG = 6'h07;
  localparam logic [5:0] OP_AND_REG = 6'h05;
  localparam logic [1:0] OP_BIT     = 2'h1;
  localparam logic [1:0] BIT_CLR    = 2'h0;
  localparam logic [1:0] BIT_SET    = 2'h1;
  localparam logic [1:0] BIT_TSZ    = 2'h2;
  localparam logic [1:0] BIT_TSO    = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0]          acc;
    logic                carry;
    logic                nibble;
    logic                zero;
    logic                skip;
    logic [6:0]          faddr;
    logic [7:0]          latch;
    logic [127:0][7:0]   mem;
    logic [7:0]          pins_s1;
    logic [7:0]          pins_s2;
    logic                awready;
    logic                wready;
    logic                aw_full;
    logic                w_full;
    logic [ADDR_W-1:0]   aw_addr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } abx_state_t;

endpackage
`default_nettype wire

// [src/abx_exec_unit.sv]
// Contract
// - Add-immediate adds 8-bit literal to accumulator, result to accumulator, all three flags
// - Add-register adds accumulator and file register 0..127, all three flags from sum
// - Register operations: destination bit 0 writes accumulator, 1 writes file register
// - And-immediate ANDs literal into accumulator, only zero flag changes
// - And-register ANDs accumulator with file register to destination, only zero flag
// - Bit clear zeroes indexed bit of file register, nothing else changes
// - Bit set forces indexed bit to one, nothing else changes
// - Test-skip-if-one with bit set discards next instruction as no-operation
// - Test-skip-if-zero with bit clear discards next instruction as no-operation
// - Port register read-modify-write uses sensed pin values, not output latch
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module abx_exec_unit
  import abx_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  input  wire logic [7:0]        i_port_pins,
  output logic      [7:0]        o_port_latch,
  input  wire logic [ADDR_W-1:0] i_axi_awaddr,
  input  wire logic              i_axi_awvalid,
  output logic                   o_axi_awready,
  input  wire logic [31:0]       i_axi_wdata,
  input  wire logic [3:0]        i_axi_wstrb,
  input  wire logic              i_axi_wvalid,
  output logic                   o_axi_wready,
  output logic [1:0]             o_axi_bresp,
  output logic                   o_axi_bvalid,
  input  wire logic              i_axi_bready,
  input  wire logic [ADDR_W-1:0] i_axi_araddr,
  input  wire logic              i_axi_arvalid,
  output logic                   o_axi_arready,
  output logic [31:0]            o_axi_rdata,
  output logic [1:0]             o_axi_rresp,
  output logic                   o_axi_rvalid,
  input  wire logic              i_axi_rready
);

  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    full = {1'b0, a} + {1'b0, b};
    return {full[8], lo[4], full[7:0]};
  endfunction

  abx_state_t st_reg;
  abx_state_t st_next;

  logic        do_wr;
  logic        is_instr;
  logic        run;
  logic [13:0] op;
  logic [6:0]  fa;
  logic [2:0]  bsel;
  logic        dsel;
  logic [7:0]  opnd;
  logic [9:0]  sum_k;
  logic [9:0]  sum_f;
  logic [7:0]  res;

  // Write fires once both halves are held and the previous response is gone
  assign do_wr    = st_reg.aw_full & st_reg.w_full & ~st_reg.bvalid;
  assign is_instr = do_wr & (st_reg.aw_addr == OFS_INSTR) & (&st_reg.wstrb[1:0]);
  assign run      = is_instr & ~st_reg.skip;
  assign op       = st_reg.wdata[13:0];
  assign fa       = op[6:0];
  assign bsel     = op[9:7];
  assign dsel     = op[7];
  // Port operand from synchronised pins, so read-modify-write never reuses a stale latch value
  assign opnd     = (fa == PORT_ADDR) ? st_reg.pins_s2 : st_reg.mem[fa];
  assign sum_k    = add8(st_reg.acc, op[7:0]);
  assign sum_f    = add8(st_reg.acc, opnd);

  always_comb begin
    st_next         = st_reg;
    res             = opnd;
    st_next.pins_s1 = i_port_pins;
    st_next.pins_s2 = st_reg.pins_s1;
    if (st_reg.awready && i_axi_awvalid) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = i_axi_awaddr;
    end
    if (st_reg.wready && i_axi_wvalid) begin
      st_next.w_full = 1'b1;
      st_next.wdata  = i_axi_wdata;
      st_next.wstrb  = i_axi_wstrb;
    end
    if (st_reg.bvalid && i_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (do_wr) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = RESP_OKAY;
      unique case (st_reg.aw_addr)
        OFS_INSTR: begin
          if (is_instr && st_reg.skip) begin
            st_next.skip = 1'b0;
          end else if (run) begin
            if (op[13:9] == OP_ADD_IMM) begin
              {st_next.carry, st_next.nibble, st_next.acc} = sum_k;
              st_next.zero = (sum_k[7:0] == 8'h00);
            end else if (op[13:8] == OP_AND_IMM) begin
              st_next.acc  = st_reg.acc & op[7:0];
              st_next.zero = ((st_reg.acc & op[7:0]) == 8'h00);
            end else if (op[13:8] == OP_ADD_REG || op[13:8] == OP_AND_REG) begin
              if (op[13:8] == OP_ADD_REG) begin
                res            = sum_f[7:0];
                st_next.carry  = sum_f[9];
                st_next.nibble = sum_f[8];
              end else begin
                res = st_reg.acc & opnd;
              end
              st_next.zero = (res == 8'h00);
              if (!dsel) begin
                st_next.acc = res;
              end else if (fa == PORT_ADDR) begin
                st_next.latch = res;
              end else begin
                st_next.mem[fa] = res;
              end
            end else if (op[13:12] == OP_BIT) begin
              unique case (op[11:10])
                BIT_CLR: res[bsel] = 1'b0;
                BIT_SET: res[bsel] = 1'b1;
                BIT_TSZ: st_next.skip = ~opnd[bsel];
                BIT_TSO: st_next.skip = opnd[bsel];
              endcase
              if (!op[11]) begin
                if (fa == PORT_ADDR) begin
                  st_next.latch = res;
                end else begin
                  st_next.mem[fa] = res;
                end
              end
            end
          end
        end
        OFS_ACC: begin
          if (st_reg.wstrb[0]) st_next.acc = st_reg.wdata[7:0];
        end
        OFS_STATUS: begin
          if (st_reg.wstrb[0]) begin
            st_next.carry  = st_reg.wdata[ST_CARRY];
            st_next.nibble = st_reg.wdata[ST_NIBBLE];
            st_next.zero   = st_reg.wdata[ST_ZERO];
          end
        end
        OFS_FADDR: begin
          if (st_reg.wstrb[0]) st_next.faddr = st_reg.wdata[6:0];
        end
        OFS_FDATA: begin
          if (st_reg.wstrb[0]) begin
            if (st_reg.faddr == PORT_ADDR) st_next.latch = st_reg.wdata[7:0];
            else st_next.mem[st_reg.faddr] = st_reg.wdata[7:0];
          end
        end
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    st_next.awready = ~st_next.aw_full;
    st_next.wready  = ~st_next.w_full;
    if (st_reg.rvalid && i_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (st_reg.arready && i_axi_arvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      unique case (i_axi_araddr)
        OFS_INSTR:  st_next.rdata = 32'h0000_0000;
        OFS_ACC:    st_next.rdata[7:0] = st_reg.acc;
        OFS_STATUS: st_next.rdata[3:0] = {st_reg.skip, st_reg.zero, st_reg.nibble, st_reg.carry};
        OFS_FADDR:  st_next.rdata[6:0] = st_reg.faddr;
        OFS_FDATA:  st_next.rdata[7:0] = (st_reg.faddr == PORT_ADDR) ? st_reg.pins_s2
                                                                     : st_reg.mem[st_reg.faddr];
        default:    st_next.rresp = RESP_SLVERR;
      endcase
    end
    st_next.arready = ~st_next.rvalid;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg         <= '0;
      st_reg.acc     <= RST_ACC;
      st_reg.latch   <= RST_LATCH;
      st_reg.faddr   <= RST_FADDR;
      st_reg.mem     <= RST_MEM;
      st_reg.awready <= 1'b1;
      st_reg.wready  <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_port_latch  = st_reg.latch;
  assign o_axi_awready = st_reg.awready;
  assign o_axi_wready  = st_reg.wready;
  assign o_axi_bresp   = st_reg.bresp;
  assign o_axi_bvalid  = st_reg.bvalid;
  assign o_axi_arready = st_reg.arready;
  assign o_axi_rdata   = st_reg.rdata;
  assign o_axi_rresp   = st_reg.rresp;
  assign o_axi_rvalid  = st_reg.rvalid;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  property p_add_lit;
    run && op[13:9] == OP_ADD_IMM |=>
      {st_reg.carry, st_reg.acc} == {1'b0, $past(st_reg.acc)} + {1'b0, $past(op[7:0])};
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add immediate result wrong");

  property p_add_reg;
    run && op[13:8] == OP_ADD_REG && !dsel |=>
      {st_reg.carry, st_reg.acc} == {1'b0, $past(st_reg.acc)} + {1'b0, $past(opnd)};
  endproperty
  a_add_reg: assert property (p_add_reg) else $error("add register result wrong");

  property p_dest_file;
    run && op[13:8] == OP_ADD_REG && dsel && fa != PORT_ADDR |=>
      st_reg.acc == $past(st_reg.acc) && st_reg.mem[$past(fa)] == $past(sum_f[7:0]);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("destination select wrong");

  property p_and_lit;
    run && op[13:8] == OP_AND_IMM |=> st_reg.acc == ($past(st_reg.acc) & $past(op[7:0]))
      && $stable(st_reg.carry) && $stable(st_reg.nibble) && st_reg.zero == (st_reg.acc == 8'h00);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and immediate wrong");

  property p_and_reg;
    run && op[13:8] == OP_AND_REG && !dsel |=> $stable(st_reg.carry) && $stable(st_reg.nibble)
      && st_reg.zero == (st_reg.acc == 8'h00);
  endproperty
  a_and_reg: assert property (p_and_reg) else $error("and register flags wrong");

  property p_bit_clr;
    run && op[13:10] == {OP_BIT, BIT_CLR} && fa != PORT_ADDR |=>
      !st_reg.mem[$past(fa)][$past(bsel)] && $stable(st_reg.zero) && $stable(st_reg.carry);
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");

  property p_bit_set;
    run && op[13:10] == {OP_BIT, BIT_SET} && fa != PORT_ADDR |=>
      st_reg.mem[$past(fa)][$past(bsel)] && $stable(st_reg.zero) && $stable(st_reg.acc);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

  property p_skip_one;
    run && op[13:10] == {OP_BIT, BIT_TSO} |=> st_reg.skip == $past(opnd[bsel]);
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip if one wrong");

  property p_skip_zero;
    run && op[13:10] == {OP_BIT, BIT_TSZ} |=> st_reg.skip == !$past(opnd[bsel]);
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("skip if zero wrong");

  property p_port_src;
    run && op[13:8] == OP_AND_REG && !dsel && fa == PORT_ADDR |=>
      st_reg.acc == ($past(st_reg.acc) & $past(st_reg.pins_s2));
  endproperty
  a_port_src: assert property (p_port_src) else $error("port operand not from pins");

  property p_one_cycle;
    is_instr |=> st_reg.bvalid && !st_reg.aw_full && (!st_reg.skip || $past(run));
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("instruction took too long");

  property p_skip_discard;
    is_instr && st_reg.skip |=> !st_reg.skip && $stable(st_reg.acc) && $stable(st_reg.mem);
  endproperty
  a_skip_discard: assert property (p_skip_discard) else $error("skip slot not idle");

  c_add_carry: cover property (run && op[13:9] == OP_ADD_IMM ##1 st_reg.carry);
  c_skip: cover property (run && op[13:12] == OP_BIT ##1 st_reg.skip ##[1:20] is_instr);
  c_port: cover property (run && fa == PORT_ADDR && dsel);

endmodule // abx_exec_unit
`default_nettype wire

// [verif/abx_exec_unit_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module abx_exec_unit_bench
  import abx_pkg::*;
;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic [7:0]        pins = 8'h5A;
  logic [7:0]        latch;
  logic [ADDR_W-1:0] awaddr = '0;
  logic              awvalid = 1'b0;
  logic              awready;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = 4'h0;
  logic              wvalid = 1'b0;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic              arvalid = 1'b0;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready = 1'b0;
  int                miscompares = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  logic [1:0]        skind [4] = '{BIT_TSO, BIT_TSO, BIT_TSZ, BIT_TSZ};
  logic [2:0]        sbit  [4] = '{3'h7, 3'h0, 3'h0, 3'h7};
  logic              sexp  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  abx_exec_unit dut_u (
    .i_clk_sys     (clk),
    .i_resetn      (resetn),
    .i_port_pins   (pins),
    .o_port_latch  (latch),
    .i_axi_awaddr  (awaddr),
    .i_axi_awvalid (awvalid),
    .o_axi_awready (awready),
    .i_axi_wdata   (wdata),
    .i_axi_wstrb   (wstrb),
    .i_axi_wvalid  (wvalid),
    .o_axi_wready  (wready),
    .o_axi_bresp   (bresp),
    .o_axi_bvalid  (bvalid),
    .i_axi_bready  (bready),
    .i_axi_araddr  (araddr),
    .i_axi_arvalid (arvalid),
    .o_axi_arready (arready),
    .o_axi_rdata   (rdata),
    .o_axi_rresp   (rresp),
    .o_axi_rvalid  (rvalid),
    .i_axi_rready  (rready)
  );

  always #4 clk = ~clk;

  task automatic report_and_stop();
    $display("samples_checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each channel drops its valid at its own handshake edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, 4'hF, RESP_OKAY);
  endtask

  task automatic instr(input logic [31:0] op);
    wr(OFS_INSTR, op);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  function automatic logic [31:0] op_lit(input logic [5:0] o, input logic [7:0] k);
    return {18'h0, o, k};
  endfunction

  function automatic logic [31:0] op_reg(input logic [3:0] o, input logic d, input logic [6:0] f);
    return {18'h0, 2'h0, o, d, f};
  endfunction

  function automatic logic [31:0] op_bit(input logic [1:0] k, input logic [2:0] b,
                                         input logic [6:0] f);
    return {18'h0, OP_BIT, k, b, f};
  endfunction

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  acc;
    logic [7:0]  m;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd_chk(OFS_ACC, 32'h0);
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_INSTR, 32'h0);
    axi_write(8'h14, 32'h0, 4'hF, RESP_SLVERR);
    axi_read(8'h14, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check(d, 32'h0);
    wr(OFS_ACC, 32'h8F);
    instr(op_lit(6'h3E, 8'h71));
    rd_chk(OFS_ACC, 32'h0);
    rd_chk(OFS_STATUS, 32'h7);
    wr(OFS_ACC, 32'h3C);
    instr(op_lit(6'h3F, 8'h05));
    rd_chk(OFS_STATUS, 32'h2);
    // Single-byte strobe must leave the instruction unexecuted
    axi_write(OFS_INSTR, op_lit(6'h3E, 8'h01), 4'h1, RESP_OKAY);
    rd_chk(OFS_ACC, 32'h41);
    wr(OFS_STATUS, 32'h3);
    wr(OFS_ACC, 32'hF0);
    instr(op_lit(6'h39, 8'h0F));
    rd_chk(OFS_STATUS, 32'h7);
    wr(OFS_ACC, 32'hFF);
    instr(op_lit(6'h39, 8'h3C));
    rd_chk(OFS_ACC, 32'h3C);
    rd_chk(OFS_STATUS, 32'h3);
    wr(OFS_FADDR, 32'h7F);
    rd_chk(OFS_FADDR, 32'h7F);
    wr(OFS_FDATA, 32'h18);
    wr(OFS_ACC, 32'h09);
    instr(op_reg(4'h7, 1'b0, 7'h7F));
    rd_chk(OFS_ACC, 32'h21);
    rd_chk(OFS_STATUS, 32'h2);
    rd_chk(OFS_FDATA, 32'h18);
    instr(op_reg(4'h7, 1'b1, 7'h7F));
    rd_chk(OFS_FDATA, 32'h39);
    rd_chk(OFS_STATUS, 32'h0);
    wr(OFS_STATUS, 32'h3);
    instr(op_reg(4'h5, 1'b1, 7'h7F));
    rd_chk(OFS_FDATA, 32'h21);
    rd_chk(OFS_STATUS, 32'h3);
    wr(OFS_ACC, 32'h12);
    instr(op_reg(4'h5, 1'b0, 7'h7F));
    rd_chk(OFS_ACC, 32'h0);
    rd_chk(OFS_STATUS, 32'h7);
    for (int b = 0; b < 8; b++) begin
      m = 8'h01 << b;
      wr(OFS_FDATA, 32'hFF);
      instr(op_bit(BIT_CLR, 3'(b), 7'h7F));
      rd_chk(OFS_FDATA, {24'h0, ~m});
      wr(OFS_FDATA, 32'h0);
      instr(op_bit(BIT_SET, 3'(b), 7'h7F));
      rd_chk(OFS_FDATA, {24'h0, m});
    end
    rd_chk(OFS_STATUS, 32'h7);
    wr(OFS_ACC, 32'h10);
    acc = 8'h10;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_STATUS, 32'h7);
      instr(op_bit(skind[i], sbit[i], 7'h7F));
      rd_chk(OFS_STATUS, {28'h0, sexp[i], 3'h7});
      instr(op_lit(6'h3E, 8'h01));
      if (!sexp[i]) acc = acc + 8'h01;
      rd_chk(OFS_ACC, {24'h0, acc});
      rd_chk(OFS_STATUS, sexp[i] ? 32'h7 : 32'h0);
    end
    pins <= 8'hA5;
    wr(OFS_FADDR, 32'(PORT_ADDR));
    wr(OFS_FDATA, 32'hFF);
    check({24'h0, latch}, 32'hFF);
    rd_chk(OFS_FDATA, 32'hA5);
    instr(op_bit(BIT_SET, 3'h1, PORT_ADDR));
    check({24'h0, latch}, 32'hA7);
    instr(op_reg(4'h7, 1'b1, PORT_ADDR));
    check({24'h0, latch}, 32'hB7);
    instr(op_reg(4'h5, 1'b0, PORT_ADDR));
    rd_chk(OFS_ACC, 32'h0);
    rd_chk(OFS_STATUS, 32'h4);
    report_and_stop();
  end
endmodule // abx_exec_unit_bench
`default_nettype wire
